// *** hdl/cbq_top.sv ***
// Purpose: Complex breakpoint qualification for eight instruction and four data breakpoints.
// Assumes: Match inputs describe the instruction at the final pipeline stage in the same cycle.
// Notes: Action outputs are registered, so a break lands on the following instruction.
`timescale 1ns/1ps
`include "cbq_consts.svh"
module cbq_top
   import cbq_pkg::*;
#(
   parameter int IPC_W = `CBQ_IPC_WIDTH,
   parameter int DPC_W = `CBQ_DPC_WIDTH
) (
   input  wire logic                             CLK_SYS,
   input  wire logic                             NRST,
   input  wire logic                             INSTR_VALID,
   input  wire logic                             INSTR_EXCEPTION,
   input  wire logic [`CBQ_NUM_INSTR-1:0]        I_MATCH,
   input  wire logic [`CBQ_NUM_DATA-1:0]         D_ADDR_MATCH,
   input  wire logic [`CBQ_NUM_DATA-1:0]         D_DATA_MATCH,
   input  wire logic [`CBQ_NUM_INSTR-1:0]        INSTR_TRIGGER_ENABLE,
   input  wire logic [`CBQ_NUM_DATA-1:0]         DATA_TRIGGER_ENABLE,
   input  wire logic [`CBQ_NUM_INSTR-1:0]        INSTR_CCTL_WR,
   input  wire logic [`CBQ_CCTL_WIDTH-1:0]       INSTR_CCTL_WDATA,
   input  wire logic [`CBQ_NUM_DATA-1:0]         DATA_CCTL_WR,
   input  wire logic [`CBQ_CCTL_WIDTH-1:0]       DATA_CCTL_WDATA,
   input  wire logic [`CBQ_NUM_INSTR-1:0]        INSTR_PASS_COUNT_WR,
   input  wire logic [IPC_W-1:0]                 INSTR_PASS_COUNT_WDATA,
   input  wire logic [`CBQ_NUM_DATA-1:0]         DATA_PASS_COUNT_WR,
   input  wire logic [DPC_W-1:0]                 DATA_PASS_COUNT_WDATA,
   output logic      [`CBQ_NUM_INSTR-1:0]        I_ACTION,
   output logic      [`CBQ_NUM_DATA-1:0]         D_ACTION,
   output logic      [`CBQ_NUM_INSTR-1:0]        I_PRIMED,
   output logic      [`CBQ_NUM_DATA-1:0]         D_PRIMED,
   output logic      [`CBQ_NUM_INSTR-1:0]        I_QUALIFIED,
   output logic      [`CBQ_NUM_INSTR-1:0]        INSTR_COMPLEX_BREAK_ENABLE,
   output logic      [`CBQ_NUM_DATA-1:0]         ANY_COMPLEX_BREAK_ENABLE,
   output logic      [`CBQ_NUM_INSTR-1:0]        INSTR_PASS_EN,
   output logic      [`CBQ_NUM_DATA-1:0]         DATA_PASS_EN,
   output logic      [`CBQ_NUM_INSTR*IPC_W-1:0]  INSTR_PASS_COUNT_REG,
   output logic      [`CBQ_NUM_DATA*DPC_W-1:0]   DATA_PASS_COUNT_REG
);
   localparam int NI = `CBQ_NUM_INSTR;
   localparam int ND = `CBQ_NUM_DATA;

   // Fixed priming source map; returns an index into the combined source vector
   // (instruction breakpoints first, data breakpoints from the data base upward).
   function automatic cbq_src_idx_t prime_src(input logic is_data, input logic [2:0] idx, input cbq_psel_t sel);
      cbq_src_idx_t r;
      r = 4'h0;
      if (is_data) begin
         unique case (sel)
            2'h1:    r = {1'b0, idx[1:0], 1'b0}; // RQ17
            2'h2:    r = {1'b0, idx[1:0], 1'b1}; // RQ17
            2'h3:    r = `CBQ_SRC_DATA_BASE + {2'h0, 2'(idx[1:0] + 2'h1)}; // RQ17
            default: r = 4'h0;
         endcase
      end else begin
         unique case (sel)
            2'h1:    r = {1'b0, idx[2:1], ~idx[0]}; // RQ17
            2'h2:    r = `CBQ_SRC_DATA_BASE + {2'h0, idx[2:1]}; // RQ17
            2'h3:    r = `CBQ_SRC_DATA_BASE + {2'h0, 2'(idx[2:1] + 2'h1)}; // RQ17
            default: r = 4'h0;
         endcase
      end
      return r;
   endfunction : prime_src

   // Configuration state held from the complex control writes.
   logic      [NI-1:0] i_cbe_q, i_cbe_d;
   logic      [NI-1:0] i_dq_q, i_dq_d;
   cbq_psel_t          i_psel_q [NI];
   cbq_psel_t          i_psel_d [NI];
   logic      [ND-1:0] d_cbe_q, d_cbe_d;
   logic      [ND-1:0] d_tup_q, d_tup_d;
   cbq_psel_t          d_psel_q [ND];
   cbq_psel_t          d_psel_d [ND];

   // Dynamic qualifier state and registered actions.
   logic [NI-1:0]      i_primed_q, i_primed_d;
   logic [ND-1:0]      d_primed_q, d_primed_d;
   logic [NI-1:0]      i_qual_q, i_qual_d;
   logic [NI-1:0]      i_act_q, i_act_d;
   logic [ND-1:0]      d_act_q, d_act_d;

   // Pass counter views.
   logic [IPC_W-1:0]   i_cnt [NI];
   logic [DPC_W-1:0]   d_cnt [ND];
   logic [NI-1:0]      i_pc_en;
   logic [ND-1:0]      d_pc_en;
   logic [NI-1:0]      i_dec;
   logic [ND-1:0]      d_dec;

   // Combinational evaluation terms.
   logic               upd;
   logic [NI-1:0]      i_cond, i_gated;
   logic [ND-1:0]      d_raw, d_cond, d_gated;
   logic [NI+ND-1:0]   src;

   genvar g;
   generate
      for (g = 0; g < NI; g++) begin : g_ipc
         cbq_pass_counter #(.W(IPC_W)) u_pc (
            .clk   (CLK_SYS),
            .nrst  (NRST),
            .wr    (INSTR_PASS_COUNT_WR[g]),
            .wdata (INSTR_PASS_COUNT_WDATA),
            .dec   (i_dec[g]),
            .cnt_q (i_cnt[g]),
            .en_q  (i_pc_en[g])
         ); // RQ1
         assign INSTR_PASS_COUNT_REG[g*IPC_W +: IPC_W] = i_cnt[g];
      end
      for (g = 0; g < ND; g++) begin : g_dpc
         cbq_pass_counter #(.W(DPC_W)) u_pc (
            .clk   (CLK_SYS),
            .nrst  (NRST),
            .wr    (DATA_PASS_COUNT_WR[g]),
            .wdata (DATA_PASS_COUNT_WDATA),
            .dec   (d_dec[g]),
            .cnt_q (d_cnt[g]),
            .en_q  (d_pc_en[g])
         ); // RQ1
         assign DATA_PASS_COUNT_REG[g*DPC_W +: DPC_W] = d_cnt[g];
      end
   endgenerate

   // Match evaluation. State updates only for instructions that complete without
   // an exception, so a faulting instruction cannot advance any chain.
   always_comb begin
      upd = INSTR_VALID & ~INSTR_EXCEPTION; // RQ6
      for (int i = 0; i < NI; i++) begin
         i_cond[i]  = I_MATCH[i] & ((i_psel_q[i] == `CBQ_PSEL_BYPASS) | i_primed_q[i]) // RQ16
                      & (~i_dq_q[i] | i_qual_q[i]); // RQ20
         i_gated[i] = i_cond[i] & (i_cnt[i] == '0); // RQ10
         i_dec[i]   = upd & i_cond[i] & (i_cnt[i] != '0); // RQ11
         src[i]     = i_gated[i] & (i_cbe_q[i] | INSTR_TRIGGER_ENABLE[i]); // RQ19
      end
      for (int j = 0; j < ND; j++) begin
         d_raw[j]   = D_DATA_MATCH[j] & (~d_tup_q[j] | I_MATCH[2*j]); // RQ14 RQ2
         d_cond[j]  = d_raw[j] & ((d_psel_q[j] == `CBQ_PSEL_BYPASS) | d_primed_q[j]); // RQ16
         d_gated[j] = d_cond[j] & (d_cnt[j] == '0); // RQ10
         d_dec[j]   = upd & d_cond[j] & (d_cnt[j] != '0); // RQ12
         src[NI+j]  = d_gated[j] & (d_cbe_q[j] | DATA_TRIGGER_ENABLE[j]); // RQ19
      end
   end

   // Next state. A control write clears primed and qualified state, but an event
   // in the same cycle still lands, judged by the priming selection held before the write.
   always_comb begin
      i_cbe_d    = i_cbe_q;
      i_dq_d     = i_dq_q;
      d_cbe_d    = d_cbe_q;
      d_tup_d    = d_tup_q;
      i_primed_d = i_primed_q;
      d_primed_d = d_primed_q;
      i_qual_d   = i_qual_q;
      i_act_d    = upd ? i_gated : '0; // RQ7
      d_act_d    = upd ? d_gated : '0; // RQ7
      for (int i = 0; i < NI; i++) begin
         i_psel_d[i] = i_psel_q[i];
         if (INSTR_CCTL_WR[i]) begin
            i_cbe_d[i]    = INSTR_CCTL_WDATA[`CBQ_CCTL_CBE_BIT];
            i_dq_d[i]     = INSTR_CCTL_WDATA[`CBQ_CCTL_DQ_BIT]; // RQ4
            i_psel_d[i]   = INSTR_CCTL_WDATA[`CBQ_CCTL_PSEL_MSB:`CBQ_CCTL_PSEL_LSB]; // RQ3
            i_primed_d[i] = 1'b0; // RQ18
            i_qual_d[i]   = 1'b0; // RQ21
         end
         if (upd && (i_psel_q[i] != `CBQ_PSEL_BYPASS) && src[prime_src(1'b0, 3'(i), i_psel_q[i])]) begin
            i_primed_d[i] = 1'b1; // RQ18 RQ8
         end
         // The qualifier of instruction breakpoint i is data breakpoint i/2.
         if (upd && D_ADDR_MATCH[i/2]) begin
            i_qual_d[i] = D_DATA_MATCH[i/2]; // RQ20 RQ4
         end
      end
      for (int j = 0; j < ND; j++) begin
         d_psel_d[j] = d_psel_q[j];
         if (DATA_CCTL_WR[j]) begin
            d_cbe_d[j]    = DATA_CCTL_WDATA[`CBQ_CCTL_CBE_BIT];
            d_tup_d[j]    = DATA_CCTL_WDATA[`CBQ_CCTL_TUP_BIT]; // RQ2
            d_psel_d[j]   = DATA_CCTL_WDATA[`CBQ_CCTL_PSEL_MSB:`CBQ_CCTL_PSEL_LSB]; // RQ3
            d_primed_d[j] = 1'b0; // RQ18
         end
         if (upd && (d_psel_q[j] != `CBQ_PSEL_BYPASS) && src[prime_src(1'b1, 3'(j), d_psel_q[j])]) begin
            d_primed_d[j] = 1'b1; // RQ18 RQ8
         end
      end
   end

   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         i_cbe_q    <= '0; // RQ5
         i_dq_q     <= '0; // RQ5
         d_cbe_q    <= '0; // RQ5
         d_tup_q    <= '0; // RQ5
         i_primed_q <= '0;
         d_primed_q <= '0;
         i_qual_q   <= '0;
         i_act_q    <= '0;
         d_act_q    <= '0;
         for (int i = 0; i < NI; i++) begin
            i_psel_q[i] <= `CBQ_PSEL_BYPASS; // RQ16
         end
         for (int j = 0; j < ND; j++) begin
            d_psel_q[j] <= `CBQ_PSEL_BYPASS; // RQ16
         end
      end else begin
         i_cbe_q    <= i_cbe_d;
         i_dq_q     <= i_dq_d;
         d_cbe_q    <= d_cbe_d;
         d_tup_q    <= d_tup_d;
         i_primed_q <= i_primed_d;
         d_primed_q <= d_primed_d;
         i_qual_q   <= i_qual_d;
         i_act_q    <= i_act_d;
         d_act_q    <= d_act_d;
         for (int i = 0; i < NI; i++) begin
            i_psel_q[i] <= i_psel_d[i];
         end
         for (int j = 0; j < ND; j++) begin
            d_psel_q[j] <= d_psel_d[j];
         end
      end
   end

   assign I_ACTION                   = i_act_q;
   assign D_ACTION                   = d_act_q;
   assign I_PRIMED                   = i_primed_q;
   assign D_PRIMED                   = d_primed_q;
   assign I_QUALIFIED                = i_qual_q;
   assign INSTR_COMPLEX_BREAK_ENABLE = i_cbe_q;
   assign ANY_COMPLEX_BREAK_ENABLE   = d_cbe_q;
   assign INSTR_PASS_EN              = i_pc_en;
   assign DATA_PASS_EN               = d_pc_en;
endmodule : cbq_top

// *** hdl/cbq_consts.svh ***
// Purpose: Constants for the complex breakpoint qualifier.
// Assumes: One core clock; all inputs come from logic on that clock.
// Notes: Field positions refer to the complex control write data words.
//
// Functional notes
// RQ1: Each instruction breakpoint has 8-bit pass counter, each data breakpoint 16-bit.
// RQ2: Every data breakpoint supports tuples with a fixed paired instruction breakpoint.
// RQ3: Each breakpoint offers four fixed priming choices picked by its priming field.
// RQ4: Only instruction breakpoints are data qualified, each by a fixed data breakpoint.
// RQ5: After reset all complex features are off; breakpoints act as plain ones.
// RQ6: Excepting instructions leave counters, primed and qualified state untouched.
// RQ7: Evaluate at last stage; resulting break is taken on the next instruction.
// RQ8: An enabling event is already visible to the very next instruction.
// RQ9: Counters reset to zero; nonzero write enables; each qualifying match decrements.
// RQ10: The match causing one-to-zero does not act; later matches act, no decrement.
// RQ11: With priming or qualification, decrement only once those conditions hold.
// RQ12: Tuple data counter decrements only when instruction and data both match.
// RQ13: A counter stays enabled until software writes zero to it.
// RQ14: Tuple data breakpoint matches only with its paired instruction match.
// RQ15: Software sets tuple instruction breakpoint with complex enable only, rest zero.
// RQ16: Priming resets to bypass; while unprimed, own matches are ignored.
// RQ17: Three further priming sources per breakpoint, never the breakpoint itself.
// RQ18: Primed state lives in the primed breakpoint until its control is written.
// RQ19: Priming sources are comparator outputs gated by their own prime, qualify, count.
// RQ20: Qualified after full data match; address match with data mismatch disqualifies.
// RQ21: Qualified state lives with the instruction breakpoint, cleared by control write.
`ifndef CBQ_CONSTS_SVH
`define CBQ_CONSTS_SVH

`define CBQ_NUM_INSTR      8
`define CBQ_NUM_DATA       4
`define CBQ_IPC_WIDTH      8
`define CBQ_DPC_WIDTH      16
`define CBQ_PC_RESET       16'h0000
`define CBQ_CCTL_WIDTH     4
`define CBQ_CCTL_CBE_BIT   0
`define CBQ_CCTL_DQ_BIT    1
`define CBQ_CCTL_TUP_BIT   1
`define CBQ_CCTL_PSEL_LSB  2
`define CBQ_CCTL_PSEL_MSB  3
`define CBQ_CCTL_RESET     4'h0
`define CBQ_PSEL_BYPASS    2'h0
`define CBQ_SRC_DATA_BASE  4'h8

`endif

// *** hdl/cbq_pkg.sv ***
// Purpose: Types shared by the complex breakpoint qualifier files.
// Assumes: Eight instruction and four data breakpoints.
// Notes: Constants live in cbq_consts.svh.
package cbq_pkg;
   typedef logic [1:0] cbq_psel_t;
   typedef logic [3:0] cbq_src_idx_t;
   typedef logic [3:0] cbq_cctl_t;
endpackage : cbq_pkg

// *** hdl/cbq_pass_counter.sv ***
// Purpose: One breakpoint pass counter with its sticky enable.
// Assumes: Software write and match decrement come from core-clock logic.
// Notes: A software write wins over a decrement in the same cycle.
`timescale 1ns/1ps
`include "cbq_consts.svh"
module cbq_pass_counter
   import cbq_pkg::*;
#(
   parameter int W = `CBQ_IPC_WIDTH
) (
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic         wr,
   input  wire logic [W-1:0] wdata,
   input  wire logic         dec,
   output logic      [W-1:0] cnt_q,
   output logic              en_q
);
   logic [W-1:0] cnt_d;
   logic         en_d;

   always_comb begin
      cnt_d = cnt_q;
      en_d  = en_q;
      if (wr) begin
         cnt_d = wdata; // RQ9
         en_d  = |wdata; // RQ13
      end else if (dec && (cnt_q != '0)) begin
         cnt_d = cnt_q - W'(1); // RQ9
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_q <= W'(`CBQ_PC_RESET); // RQ9
         en_q  <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         en_q  <= en_d;
      end
   end
endmodule : cbq_pass_counter

// *** verif/cbq_top_properties.sv ***
// Purpose: Port-level timing properties of the complex breakpoint qualifier.
// Assumes: Channels 0 and 3 stand for their siblings, which share the same logic.
// Notes: Cycle-one reset edges are safe because every output sits at zero in reset.
`timescale 1ns/1ps
`include "cbq_consts.svh"
module cbq_top_properties
   import cbq_pkg::*;
#(
   parameter int IPC_W = `CBQ_IPC_WIDTH,
   parameter int DPC_W = `CBQ_DPC_WIDTH
) (
   input wire logic               CLK_SYS,
   input wire logic               NRST,
   input wire logic               INSTR_VALID,
   input wire logic               INSTR_EXCEPTION,
   input wire logic [7:0]         I_MATCH,
   input wire logic [3:0]         D_ADDR_MATCH,
   input wire logic [3:0]         D_DATA_MATCH,
   input wire logic [7:0]         INSTR_CCTL_WR,
   input wire logic [3:0]         INSTR_CCTL_WDATA,
   input wire logic [3:0]         DATA_CCTL_WR,
   input wire logic [7:0]         INSTR_PASS_COUNT_WR,
   input wire logic [IPC_W-1:0]   INSTR_PASS_COUNT_WDATA,
   input wire logic [3:0]         DATA_PASS_COUNT_WR,
   input wire logic [7:0]         I_ACTION,
   input wire logic [3:0]         D_ACTION,
   input wire logic [7:0]         I_PRIMED,
   input wire logic [3:0]         D_PRIMED,
   input wire logic [7:0]         I_QUALIFIED,
   input wire logic [7:0]         INSTR_COMPLEX_BREAK_ENABLE,
   input wire logic [7:0]         INSTR_PASS_EN,
   input wire logic [8*IPC_W-1:0] INSTR_PASS_COUNT_REG,
   input wire logic [4*DPC_W-1:0] DATA_PASS_COUNT_REG
);
   logic             upd;
   logic             wr_any;
   logic [IPC_W-1:0] ic0;
   assign upd = INSTR_VALID & ~INSTR_EXCEPTION;
   assign wr_any = |{INSTR_CCTL_WR, DATA_CCTL_WR, INSTR_PASS_COUNT_WR, DATA_PASS_COUNT_WR};
   assign ic0 = INSTR_PASS_COUNT_REG[IPC_W-1:0];
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!NRST);

   property p_refuse; !upd |=> I_ACTION == 8'h00 && D_ACTION == 4'h0; endproperty
   a_refuse: assert property (p_refuse) else $error("action without a retired instruction");
   property p_frozen; !upd && !wr_any |=> $stable({I_PRIMED, D_PRIMED, I_QUALIFIED, INSTR_PASS_COUNT_REG,
      DATA_PASS_COUNT_REG}); endproperty
   a_frozen: assert property (p_frozen) else $error("state moved on an excepting instruction");
   property p_icause; I_ACTION[0] |-> $past(upd && I_MATCH[0] && ic0 == 0); endproperty
   a_icause: assert property (p_icause) else $error("instruction action without zero count match");
   property p_dcause; D_ACTION[0] |-> $past(upd && D_DATA_MATCH[0]); endproperty
   a_dcause: assert property (p_dcause) else $error("data action without a data match");
   property p_dec; $changed(ic0) && !$past(INSTR_PASS_COUNT_WR[0]) |->
      $past(upd && I_MATCH[0] && ic0 != 0) && ic0 == IPC_W'($past(ic0) - 1'b1); endproperty
   a_dec: assert property (p_dec) else $error("pass count moved other than by one on a match");
   property p_load; $past(INSTR_PASS_COUNT_WR[0] && NRST) |-> ic0 == $past(INSTR_PASS_COUNT_WDATA) &&
      INSTR_PASS_EN[0] == ($past(INSTR_PASS_COUNT_WDATA) != 0); endproperty
   a_load: assert property (p_load) else $error("pass count write not taken");
   property p_prime_hold; $fell(I_PRIMED[0]) |-> $past(INSTR_CCTL_WR[0]); endproperty
   a_prime_hold: assert property (p_prime_hold) else $error("primed state lost without a write");
   property p_qual_set; $rose(I_QUALIFIED[3]) |-> $past(upd && D_ADDR_MATCH[1] && D_DATA_MATCH[1]); endproperty
   a_qual_set: assert property (p_qual_set) else $error("qualified without full data match");
   property p_qual_clr; $past(upd && D_ADDR_MATCH[1] && !D_DATA_MATCH[1] && NRST) |-> !I_QUALIFIED[3]; endproperty
   a_qual_clr: assert property (p_qual_clr) else $error("data mismatch did not disqualify");
   property p_qual_fall; $fell(I_QUALIFIED[3]) |-> $past(INSTR_CCTL_WR[3] || (upd && D_ADDR_MATCH[1])); endproperty
   a_qual_fall: assert property (p_qual_fall) else $error("qualified state lost without cause");
endmodule : cbq_top_properties

bind cbq_top cbq_top_properties #(.IPC_W(IPC_W), .DPC_W(DPC_W)) u_cbq_top_properties (.*);

// *** verif/cbq_pipe.sv ***
// Purpose: Final pipeline stage and comparators that feed the qualifier.
// Assumes: Callers invoke the tasks one at a time from the bench.
// Notes: Idle cycles invert the match lines so stale matches cannot pass.
`timescale 1ns/1ps
module cbq_pipe (
   input  wire logic CLK_SYS,
   output logic       INSTR_VALID,
   output logic       INSTR_EXCEPTION,
   output logic [7:0] I_MATCH,
   output logic [3:0] D_ADDR_MATCH,
   output logic [3:0] D_DATA_MATCH
);
   initial begin
      {INSTR_VALID, INSTR_EXCEPTION, I_MATCH, D_ADDR_MATCH, D_DATA_MATCH} = '0;
   end
   task automatic retire(input logic x, input logic [7:0] im, input logic [3:0] am, input logic [3:0] dm);
      @(posedge CLK_SYS);
      INSTR_VALID <= 1'b1;
      INSTR_EXCEPTION <= x;
      I_MATCH <= im;
      D_ADDR_MATCH <= am;
      D_DATA_MATCH <= dm;
      #1;
   endtask : retire
   task automatic idle();
      @(posedge CLK_SYS);
      INSTR_VALID <= 1'b0;
      INSTR_EXCEPTION <= 1'b0;
      I_MATCH <= ~I_MATCH;
      D_ADDR_MATCH <= ~D_ADDR_MATCH;
      D_DATA_MATCH <= ~D_DATA_MATCH;
      #1;
   endtask : idle
endmodule : cbq_pipe

// *** verif/cbq_top_tb_top.sv ***
// Purpose: Self-checking bench for the complex breakpoint qualifier.
// Assumes: run and idl return 1 ns after the edge that launched their request; wr returns 1 ns after the edge that took it.
// Notes: Outputs checked after a call reflect the instruction before it.
`timescale 1ns/1ps
module cbq_top_tb_top;
   logic        CLK_SYS = 1'b0;
   logic        NRST, INSTR_VALID, INSTR_EXCEPTION;
   logic [7:0]  I_MATCH, INSTR_TRIGGER_ENABLE, INSTR_CCTL_WR, INSTR_PASS_COUNT_WR, INSTR_PASS_COUNT_WDATA;
   logic [3:0]  D_ADDR_MATCH, D_DATA_MATCH, DATA_TRIGGER_ENABLE, INSTR_CCTL_WDATA, DATA_CCTL_WR;
   logic [3:0]  DATA_CCTL_WDATA, DATA_PASS_COUNT_WR;
   logic [15:0] DATA_PASS_COUNT_WDATA;
   logic [7:0]  I_ACTION, I_PRIMED, I_QUALIFIED, INSTR_COMPLEX_BREAK_ENABLE, INSTR_PASS_EN;
   logic [3:0]  D_ACTION, D_PRIMED, ANY_COMPLEX_BREAK_ENABLE, DATA_PASS_EN;
   logic [63:0] INSTR_PASS_COUNT_REG, DATA_PASS_COUNT_REG;
   int          mismatches = 0;
   int          tests_run = 0;

   cbq_top  u_cbq_top (.*);
   cbq_pipe u_cbq_pipe (.*);

   always #50 CLK_SYS = ~CLK_SYS;

   task automatic end_sim();
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Kinds: 0 instr control, 1 data control, 2 instr count, 3 data count, 4 trigger enables (level).
   task automatic wr(input int k, input int n, input logic [15:0] v);
      @(posedge CLK_SYS);
      case (k)
         0: begin INSTR_CCTL_WR <= 8'h01 << n; INSTR_CCTL_WDATA <= v[3:0]; end
         1: begin DATA_CCTL_WR <= 4'h1 << n; DATA_CCTL_WDATA <= v[3:0]; end
         2: begin INSTR_PASS_COUNT_WR <= 8'h01 << n; INSTR_PASS_COUNT_WDATA <= v[7:0]; end
         3: begin DATA_PASS_COUNT_WR <= 4'h1 << n; DATA_PASS_COUNT_WDATA <= v; end
         default: begin INSTR_TRIGGER_ENABLE <= v[7:0]; DATA_TRIGGER_ENABLE <= v[11:8]; end
      endcase
      @(posedge CLK_SYS);
      {INSTR_CCTL_WR, DATA_CCTL_WR, INSTR_PASS_COUNT_WR, DATA_PASS_COUNT_WR} <= '0;
      #1;
   endtask : wr
   task automatic run(input logic x, input logic [7:0] im, input logic [3:0] am, input logic [3:0] dm);
      u_cbq_pipe.retire(x, im, am, dm);
   endtask : run
   task automatic idl();
      u_cbq_pipe.idle();
   endtask : idl

   initial begin
      repeat (5000) @(posedge CLK_SYS);
      mismatches++;
      end_sim();
   end

   initial begin
      NRST = 1'b0;
      {INSTR_TRIGGER_ENABLE, DATA_TRIGGER_ENABLE, INSTR_CCTL_WR, INSTR_CCTL_WDATA, DATA_CCTL_WR} = '0;
      {DATA_CCTL_WDATA, INSTR_PASS_COUNT_WR, INSTR_PASS_COUNT_WDATA, DATA_PASS_COUNT_WR, DATA_PASS_COUNT_WDATA} = '0;
      repeat (12) @(posedge CLK_SYS);
      NRST <= 1'b1;
      #1;
      chk({I_PRIMED, D_PRIMED, I_QUALIFIED, INSTR_PASS_EN, DATA_PASS_EN, INSTR_COMPLEX_BREAK_ENABLE}, 0);
      chk(INSTR_PASS_COUNT_REG | DATA_PASS_COUNT_REG, 0);
      run(0, 8'h81, 4'h0, 4'h9);
      run(1, 8'hff, 4'hf, 4'hf);
      chk({I_ACTION, D_ACTION}, 12'h819);
      idl();
      chk({I_ACTION, D_ACTION}, 0);
      $display("test plain done");
      wr(2, 0, 16'h0002);
      chk({INSTR_PASS_EN[0], INSTR_PASS_COUNT_REG[7:0]}, 9'h102);
      run(0, 8'h01, 0, 0);
      run(1, 8'h01, 0, 0);
      run(0, 8'h01, 0, 0);
      chk({I_ACTION[0], INSTR_PASS_COUNT_REG[7:0]}, 9'h001);
      run(0, 8'h01, 0, 0);
      chk({I_ACTION[0], INSTR_PASS_COUNT_REG[7:0]}, 9'h000);
      idl();
      chk({I_ACTION[0], INSTR_PASS_EN[0], INSTR_PASS_COUNT_REG[7:0]}, 10'h300);
      wr(2, 0, 16'h01ff);
      wr(3, 1, 16'hffff);
      chk({INSTR_PASS_COUNT_REG[7:0], DATA_PASS_COUNT_REG[31:16], INSTR_PASS_EN[0], DATA_PASS_EN[1]}, 26'h3ffffff);
      wr(2, 0, 0);
      wr(3, 1, 0);
      chk({INSTR_PASS_EN[0], DATA_PASS_EN[1]}, 0);
      $display("test pass count done");
      wr(0, 1, 16'h0004);
      run(0, 8'h01, 0, 0);
      idl();
      chk(I_PRIMED[1], 0);
      wr(4, 0, 16'h0fff);
      wr(0, 1, 16'h0004);
      run(0, 8'h02, 0, 0);
      run(0, 8'h01, 0, 0);
      chk({I_ACTION[1], I_PRIMED[1]}, 0);
      run(0, 8'h02, 0, 0);
      chk(I_PRIMED[1], 1);
      idl();
      chk(I_ACTION[1], 1);
      wr(0, 1, 0);
      chk(I_PRIMED[1], 0);
      for (int s = 1; s < 4; s++) begin
         wr(0, 2, 16'(s << 2));
         run(0, 8'h04, 0, 0);
         idl();
         chk(I_PRIMED[2], 0);
         run(0, (s == 1) ? 8'h08 : 8'h00, 0, (s == 2) ? 4'h2 : ((s == 3) ? 4'h4 : 4'h0));
         idl();
         chk(I_PRIMED[2], 1);
      end
      wr(0, 2, 0);
      wr(1, 2, 16'h0004);
      chk(D_PRIMED[2], 0);
      run(0, 8'h10, 0, 0);
      idl();
      chk(D_PRIMED[2], 1);
      wr(1, 2, 0);
      chk(D_PRIMED[2], 0);
      wr(4, 0, 0);
      $display("test priming done");
      wr(0, 0, 16'h0001);
      wr(1, 0, 16'h0002);
      chk({INSTR_COMPLEX_BREAK_ENABLE[0], ANY_COMPLEX_BREAK_ENABLE[0]}, 2'b10);
      run(0, 8'h00, 4'h1, 4'h1);
      run(0, 8'h01, 4'h1, 4'h1);
      chk(D_ACTION[0], 0);
      idl();
      chk(D_ACTION[0], 1);
      wr(3, 0, 16'h0001);
      run(0, 8'h00, 4'h1, 4'h1);
      idl();
      chk(DATA_PASS_COUNT_REG[15:0], 1);
      run(0, 8'h01, 4'h1, 4'h1);
      idl();
      chk({D_ACTION[0], DATA_PASS_COUNT_REG[15:0]}, 0);
      wr(3, 0, 0);
      wr(1, 0, 0);
      $display("test tuple done");
      wr(0, 3, 16'h0002);
      wr(2, 3, 16'h0001);
      run(0, 8'h08, 0, 0);
      idl();
      chk({I_ACTION[3], INSTR_PASS_COUNT_REG[31:24]}, 9'h001);
      run(0, 8'h00, 4'h2, 4'h2);
      run(0, 8'h08, 0, 0);
      chk(I_QUALIFIED[3], 1);
      run(0, 8'h08, 0, 0);
      chk({I_ACTION[3], INSTR_PASS_COUNT_REG[31:24]}, 0);
      idl();
      chk(I_ACTION[3], 1);
      run(0, 8'h00, 4'h2, 4'h0);
      idl();
      chk(I_QUALIFIED[3], 0);
      run(0, 8'h00, 4'h2, 4'h2);
      idl();
      wr(0, 3, 16'h0002);
      chk(I_QUALIFIED[3], 0);
      $display("test qualify done");
      end_sim();
   end
endmodule : cbq_top_tb_top
